// >>> hdl/nvm_bits.v
// Purpose: security, general purpose and calibration non-volatile bits
// Assumes: one clock, async high reset, AXI4-Lite register access
// Notes: the nonvolatile store itself sits outside; this holds its image
// Notes on behaviour
// - protection set refuses debug and fast-port accesses
// - only set-protection command sets it; no clear
// - clear protection after erase pin then full erase
// - protection clear allows all ports again
// - two retained general bits, set/clear commands
// - bit zero enables dropout detector; erase clears
// - bit one enables dropout reset; erase clears
// - eight factory calibration bits, never altered
// - test pin, lines zero one high, two low: fast mode
// - fast mode accepts the flash commands
// - all four high ten seconds starts recovery
// - recovery rewrites boot program in first sectors
// - record cause of last reset
// - decode system window at top four kilobytes
`include "nvm_bits_map.vh"
`default_nettype none
module nvm_bits #(
  parameter [31:0] ERASE_CYC   = (`ERASE_MIN_MS * (`CLK_HZ / 1000)),
  parameter [31:0] RECOVER_CYC = (`RECOVER_S * `CLK_HZ),
  parameter [7:0]  CAL_VALUE   = 8'h5a  // arbitrary factory value
) (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // axi4-lite slave
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire        irq,
  // pins
  input  wire        erase_pin,
  input  wire        test_mode_pin,
  input  wire        port_line_zero,
  input  wire        port_line_one,
  input  wire        port_line_two,
  // flash engine
  input  wire        full_erase_done,
  input  wire        recovery_done,
  output reg         recovery_start,
  // access requests from debug and fast programming port
  input  wire        debug_req,
  output wire        debug_grant,
  input  wire        fast_req,
  output wire        fast_grant,
  output wire        fast_mode,
  // reset cause inputs, one-cycle pulses
  input  wire        rst_soft,
  input  wire        rst_user,
  input  wire        rst_wdog,
  input  wire        rst_drop,
  // level outputs
  output wire        protect_bit,
  output wire        dropout_det_en,
  output wire        dropout_rst_en,
  output wire [7:0]  cal_bits,
  // system window decode
  input  wire [31:0] sys_addr,
  output wire        sys_sel
);

  localparam IRQW = `IRQ_W;

  // nonvolatile bit images
  reg             prot_q;
  reg  [1:0]      gp_q;
  // pin synchroniser chains and accepted levels
  reg  [2:0]      s_erase_q;
  reg  [2:0]      s_tst_q;
  reg  [2:0]      s_p0_q;
  reg  [2:0]      s_p1_q;
  reg  [2:0]      s_p2_q;
  reg             erase_q;
  reg             tst_q;
  reg             p0_q;
  reg             p1_q;
  reg             p2_q;
  // erase and recovery timers
  reg  [31:0]     ecnt_q;
  reg             erase_ok_q;
  reg  [31:0]     rcnt_q;
  reg             rec_busy_q;
  // reset cause and interrupt state
  reg  [2:0]      cause_q;
  reg  [IRQW-1:0] ist_q;
  reg  [IRQW-1:0] imask_q;
  // write channel holding registers
  reg  [31:0]     awaddr_q;
  reg  [31:0]     wdata_q;
  reg             aw_q;
  reg             w_q;

  // debounce helper: change only when second and third stages agree
  function upd;
    input [2:0] s;
    input       cur;
    begin
      upd = (s[1] == s[2]) ? s[2] : cur;
    end
  endfunction

  // register page decode, shared by the write and read paths
  function in_page;
    input [31:0] addr;
    begin
      in_page = (addr[31:8] == 24'h0);
    end
  endfunction

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_erase_q <= 3'h0;
      s_tst_q <= 3'h0;
      s_p0_q <= 3'h0;
      s_p1_q <= 3'h0;
      s_p2_q <= 3'h0;
    end else begin
      s_erase_q <= {s_erase_q[1:0], erase_pin};
      s_tst_q <= {s_tst_q[1:0], test_mode_pin};
      s_p0_q <= {s_p0_q[1:0], port_line_zero};
      s_p1_q <= {s_p1_q[1:0], port_line_one};
      s_p2_q <= {s_p2_q[1:0], port_line_two};
    end
  end

  // a level is accepted only once stages two and three agree
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      erase_q <= 1'b0;
      tst_q <= 1'b0;
      p0_q <= 1'b0;
      p1_q <= 1'b0;
      p2_q <= 1'b0;
    end else begin
      erase_q <= upd(s_erase_q, erase_q);
      tst_q <= upd(s_tst_q, tst_q);
      p0_q <= upd(s_p0_q, p0_q);
      p1_q <= upd(s_p1_q, p1_q);
      p2_q <= upd(s_p2_q, p2_q);
    end
  end

  assign fast_mode = tst_q & p0_q & p1_q & ~p2_q;
  wire rec_pins = tst_q & p0_q & p1_q & p2_q;

  // axi write path
  wire aw_take = s_axi_awvalid & ~aw_q;
  wire w_take  = s_axi_wvalid & ~w_q;
  assign s_axi_awready = ~aw_q;
  assign s_axi_wready  = ~w_q;
  wire [31:0] wa = aw_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_q ? wdata_q : s_axi_wdata;
  wire have_aw = aw_q | aw_take;
  wire have_w  = w_q | w_take;
  wire wr_do = have_aw & have_w & ~s_axi_bvalid;
  wire wr_hit = (wa[7:0] == `REG_CTRL) | (wa[7:0] == `REG_IRQ_STAT) |
                (wa[7:0] == `REG_IRQ_MASK);
  // a write to a writable register with byte lane 0 off is answered okay and dropped
  wire wr_ok = wr_do & in_page(wa) & wr_hit & s_axi_wstrb[0];
  wire [3:0] cmd = (wr_ok && wa[7:0] == `REG_CTRL) ? wd[3:0] : `CMD_NONE;

  // erase pin must be seen longer than the minimum before it counts
  wire erase_long = erase_q & (ecnt_q >= ERASE_CYC);

  // event sources
  wire ev_done = (cmd != `CMD_NONE);
  // refused re-sets every cycle a blocked request is held
  wire ev_ref  = (debug_req | fast_req) & prot_q;
  wire ev_er   = erase_ok_q & full_erase_done;
  wire ev_rec  = rec_busy_q & recovery_done;
  wire [IRQW-1:0] ev;
  assign ev[`IRQ_CMD_DONE]  = ev_done;
  assign ev[`IRQ_REFUSED]   = ev_ref;
  assign ev[`IRQ_ERASED]    = ev_er;
  assign ev[`IRQ_RECOVERED] = ev_rec;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
      ist_q <= {IRQW{1'b0}};
      imask_q <= {IRQW{1'b0}};
    end else begin
      if (wr_do) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // read-only or unmapped targets answer slverr, change nothing
        s_axi_bresp <= (in_page(wa) && wr_hit) ? 2'h0 : 2'h2;
      end else begin
        if (aw_take) begin
          aw_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (w_take) begin
          w_q <= 1'b1;
          wdata_q <= s_axi_wdata;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
      if (wr_ok && wa[7:0] == `REG_IRQ_MASK)
        imask_q <= wd[IRQW-1:0];
      // set wins over write-one-to-clear
      if (wr_ok && wa[7:0] == `REG_IRQ_STAT)
        ist_q <= (ist_q & ~wd[IRQW-1:0]) | ev;
      else
        ist_q <= ist_q | ev;
      if (s_axi_rvalid) begin
        if (s_axi_rready)
          s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid) begin
        // read data is launched here and stands until rready
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        s_axi_rdata <= 32'h0;
        if (!in_page(s_axi_araddr))
          s_axi_rresp <= 2'h2;
        else case (s_axi_araddr[7:0])
          `REG_CTRL: s_axi_rdata <= 32'h0;
          `REG_STATE: s_axi_rdata <= {26'h0, rec_busy_q, fast_mode,
                                      erase_ok_q, gp_q, prot_q};
          `REG_IRQ_STAT: s_axi_rdata <= {28'h0, ist_q};
          `REG_IRQ_MASK: s_axi_rdata <= {28'h0, imask_q};
          `REG_RST_CAUSE: s_axi_rdata <= {29'h0, cause_q};
          `REG_CAL: s_axi_rdata <= {24'h0, CAL_VALUE};
          default: s_axi_rresp <= 2'h2;
        endcase
      end
    end
  end
  assign s_axi_arready = ~s_axi_rvalid;
  // level output: only the sticky bits remember an event
  assign irq = |(ist_q & imask_q);

  // protection and general bits
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ecnt_q <= 32'h0;
      erase_ok_q <= 1'b0;
      prot_q <= 1'b0;
      gp_q <= 2'b00;
    end else begin
      // a short press leaves the counter below the limit: ignored
      ecnt_q <= erase_q ? ((ecnt_q >= ERASE_CYC) ? ecnt_q : ecnt_q + 32'h1)
                        : 32'h0;
      // armed by the pin, then waits for the whole-array erase
      if (erase_long)
        erase_ok_q <= 1'b1;
      else if (ev_er)
        erase_ok_q <= 1'b0;
      if (cmd == `CMD_SET_PROT)
        prot_q <= 1'b1;
      else if (ev_er)
        prot_q <= 1'b0;
      if (erase_long)
        gp_q <= 2'b00;
      else begin
        if (cmd == `CMD_SET_GP0)
          gp_q[0] <= 1'b1;
        else if (cmd == `CMD_CLR_GP0)
          gp_q[0] <= 1'b0;
        if (cmd == `CMD_SET_GP1)
          gp_q[1] <= 1'b1;
        else if (cmd == `CMD_CLR_GP1)
          gp_q[1] <= 1'b0;
      end
    end
  end

  // recovery hold timer
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rcnt_q <= 32'h0;
      rec_busy_q <= 1'b0;
      recovery_start <= 1'b0;
    end else begin
      recovery_start <= 1'b0;
      // counter saturates so a held strap cannot restart it
      if (!rec_pins)
        rcnt_q <= 32'h0;
      else if (rcnt_q < RECOVER_CYC)
        rcnt_q <= rcnt_q + 32'h1;
      // one shot per power cycle; the board must be repowered after
      if (rec_pins && rcnt_q == RECOVER_CYC - 32'h1 && !rec_busy_q) begin
        rec_busy_q <= 1'b1;
        recovery_start <= 1'b1;
      end
    end
  end

  // cause of last reset; sys_rst itself is the power-up case
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      cause_q <= `CAUSE_POWER;
    // a dropout outranks the others if two land together
    else if (rst_drop)
      cause_q <= `CAUSE_DROP;
    else if (rst_wdog)
      cause_q <= `CAUSE_WDOG;
    else if (rst_user)
      cause_q <= `CAUSE_USER;
    else if (rst_soft)
      cause_q <= `CAUSE_SOFT;
  end

  // combinational grants: protection blocks at once, no stale cycle
  assign debug_grant = debug_req & ~prot_q;
  assign fast_grant = fast_req & fast_mode & ~prot_q;
  assign protect_bit = prot_q;
  assign dropout_det_en = gp_q[0];
  assign dropout_rst_en = gp_q[1];
  assign cal_bits = CAL_VALUE;
  assign sys_sel = ((sys_addr & `SYS_MASK) == `SYS_BASE);

endmodule // nvm_bits
`default_nettype wire

// >>> hdl/nvm_bits_map.vh
// Purpose: constants for the non-volatile security and config bit block
// Assumes: AXI4-Lite word registers, 25 MHz clock
// Notes: offsets are byte addresses
`ifndef NVM_BITS_MAP_VH
`define NVM_BITS_MAP_VH
`define REG_CTRL        8'h00
`define REG_STATE       8'h04
`define REG_IRQ_STAT    8'h08
`define REG_IRQ_MASK    8'h0c
`define REG_RST_CAUSE   8'h10
`define REG_CAL         8'h14
// command codes written to REG_CTRL[3:0]
`define CMD_NONE        4'h0
`define CMD_SET_PROT    4'h1
`define CMD_SET_GP0     4'h2
`define CMD_CLR_GP0     4'h3
`define CMD_SET_GP1     4'h4
`define CMD_CLR_GP1     4'h5
// reset cause encodings
`define CAUSE_POWER     3'h0
`define CAUSE_SOFT      3'h1
`define CAUSE_USER      3'h2
`define CAUSE_WDOG      3'h3
`define CAUSE_DROP      3'h4
// irq status bits
`define IRQ_CMD_DONE    0
`define IRQ_REFUSED     1
`define IRQ_ERASED      2
`define IRQ_RECOVERED   3
`define IRQ_W           4
// timing
`define CLK_HZ          25000000
`define ERASE_MIN_MS    50
`define RECOVER_S       10
// system window
`define SYS_BASE        32'hfffff000
`define SYS_MASK        32'hfffff000
`endif

// >>> test/flash_engine_model.sv
// Purpose: flash engine and erase programmer model
// Assumes: bench pulses erase_go for one cycle
// Notes: pin held HOLD cycles, then whole erase done later
`default_nettype none
module flash_engine_model #(
  parameter int HOLD = 34,
  parameter int RDLY = 5
) (
  input wire logic clk,
  input wire logic erase_go,
  input wire logic recovery_start,
  output var logic erase_pin,
  output var logic full_erase_done,
  output var logic recovery_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int ecnt = 0;
  int rcnt = 0;
  initial erase_pin = 1'b0;
  initial full_erase_done = 1'b0;
  initial recovery_done = 1'b0;
  always @(posedge clk) begin
    if (erase_go) ecnt <= HOLD + 6;
    else if (ecnt != 0) ecnt <= ecnt - 1;
    erase_pin <= erase_go || ecnt > 7;
    full_erase_done <= (ecnt == 1);
    if (recovery_start) rcnt <= RDLY;
    else if (rcnt != 0) rcnt <= rcnt - 1;
    recovery_done <= (rcnt == 1);
  end
endmodule // flash_engine_model
`default_nettype wire

// >>> test/nvm_bits_monitor.sv
// Purpose: port checks for nvm_bits
// Assumes: one clock, sys_rst async active high
// Notes: attached by bind at the foot
`default_nettype none
module nvm_bits_monitor #(
  parameter [7:0] CAL_VALUE = 8'h5a
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // bus response
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // flash engine
  input wire logic        full_erase_done,
  input wire logic        recovery_start,
  // access ports
  input wire logic        debug_req,
  input wire logic        debug_grant,
  input wire logic        fast_req,
  input wire logic        fast_grant,
  input wire logic        fast_mode,
  // level bits and decode
  input wire logic        protect_bit,
  input wire logic        dropout_det_en,
  input wire logic [7:0]  cal_bits,
  input wire logic [31:0] sys_addr,
  input wire logic        sys_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
  property p_dbg; debug_grant == (debug_req && !protect_bit); endproperty
  a_dbg: assert property (p_dbg) else $error("debug grant wrong");
  property p_fast;
    fast_grant == (fast_req && fast_mode && !protect_bit);
  endproperty
  a_fast: assert property (p_fast) else $error("fast grant wrong");
  property p_pset; $rose(protect_bit) |-> $rose(s_axi_bvalid); endproperty
  a_pset: assert property (p_pset) else $error("protect set no cmd");
  // clear may land one or two edges after the erase-done pulse
  property p_pclr;
    $fell(protect_bit) |-> $past(full_erase_done) || $past(full_erase_done, 2);
  endproperty
  a_pclr: assert property (p_pclr) else $error("protect cleared early");
  property p_gp0; $rose(dropout_det_en) |-> $rose(s_axi_bvalid); endproperty
  a_gp0: assert property (p_gp0) else $error("gp0 set no cmd");
  property p_cal; cal_bits == CAL_VALUE; endproperty
  a_cal: assert property (p_cal) else $error("cal bits changed");
  property p_sel; sys_sel == (sys_addr[31:12] == 20'hfffff); endproperty
  a_sel: assert property (p_sel) else $error("window decode wrong");
  property p_rec; recovery_start |-> !fast_mode ##1 !recovery_start; endproperty
  a_rec: assert property (p_rec) else $error("recovery pulse wrong");
endmodule // nvm_bits_monitor
bind nvm_bits nvm_bits_monitor #(.CAL_VALUE(CAL_VALUE)) u_mon (.*);
`default_nettype wire

// >>> test/nvm_bits_tb_top.sv
// Purpose: self-checking bench for nvm_bits
// Assumes: short erase and recovery counts
// Notes: driver queues answers, watcher compares
`include "nvm_bits_map.vh"
`default_nettype none
module nvm_bits_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = '0, sys_rst = '1, erase_go = '0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_rdata, sys_addr = '0, a;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, test_mode_pin = '0;
  logic port_line_zero = '0, port_line_one = '0, port_line_two = '0;
  logic debug_req = '0, fast_req = '0, rst_soft = '0, rst_user = '0;
  logic rst_wdog = '0, rst_drop = '0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, erase_pin;
  logic full_erase_done, recovery_done, recovery_start, debug_grant;
  logic fast_grant, fast_mode, sys_sel, protect_bit, dropout_det_en;
  logic dropout_rst_en;
  logic [7:0]  cal_bits;
  logic [33:0] exp_q[$];
  logic [3:0]  cmd[6] = '{4'h2, 4'h4, 4'h3, 4'h5, 4'h2, 4'h4};
  logic [2:0]  st[6] = '{3'h2, 3'h6, 3'h4, 3'h0, 3'h2, 3'h6};
  int error_cnt = 0, num_checks = 0, n;
  nvm_bits #(.ERASE_CYC(32'h14), .RECOVER_CYC(32'h1e)) dut (.*);
  flash_engine_model #(.HOLD(34)) model (.*);
  always #20 clk = ~clk;
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata},
                                          exp_q.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0},
                                          exp_q.pop_front());
  end
  task automatic xfer(input logic w, input logic [7:0] ad,
                      input logic [31:0] d, input logic [1:0] r);
    int k;
    @(posedge clk);
    exp_q.push_back({r, w ? 32'h0 : d});
    s_axi_awaddr <= {24'h0, ad};
    s_axi_araddr <= {24'h0, ad};
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    k = 0;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid) && k < 50);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (k >= 50) begin chk(0, 1); results(); end
  endtask
  initial begin
    void'($urandom(32'hec47a7f2));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    xfer(0, `REG_STATE, 32'h0, 2'h0);
    xfer(0, `REG_RST_CAUSE, `CAUSE_POWER, 2'h0);
    xfer(1, `REG_CAL, $urandom, 2'h2);
    xfer(0, `REG_CAL, 32'h5a, 2'h0);
    xfer(0, 8'h18, 32'h0, 2'h2);
    for (n = 0; n < 6; n++) begin
      xfer(1, `REG_CTRL, cmd[n], 2'h0);
      xfer(0, `REG_STATE, st[n], 2'h0);
    end
    chk({dropout_rst_en, dropout_det_en}, 2'h3);
    xfer(1, `REG_CTRL, `CMD_SET_PROT, 2'h0);
    {test_mode_pin, port_line_zero, port_line_one} <= 3'h7;
    {debug_req, fast_req} <= 2'h3;
    repeat (8) @(posedge clk);
    chk({fast_mode, fast_grant, debug_grant}, 3'h4);
    xfer(0, `REG_STATE, 32'h17, 2'h0);
    erase_go <= 1'b1;
    @(posedge clk);
    erase_go <= 1'b0;
    repeat (32) @(posedge clk);
    chk({protect_bit, dropout_rst_en, dropout_det_en}, 3'h4);
    repeat (14) @(posedge clk);
    chk({protect_bit, fast_grant, debug_grant}, 3'h3);
    chk(irq, 0);
    xfer(1, `REG_IRQ_MASK, 32'h4, 2'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    xfer(1, `REG_IRQ_STAT, 32'h4, 2'h0);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    port_line_two <= 1'b1;
    for (n = 0; n < 80 && recovery_start !== 1'b1; n++) @(posedge clk);
    chk(n < 80, 1);
    xfer(1, `REG_IRQ_MASK, 32'h8, 2'h0);
    repeat (10) @(posedge clk);
    chk(irq, 1);
    for (n = 0; n < 4; n++) begin
      {rst_drop, rst_wdog, rst_user, rst_soft} <= 4'h1 << n;
      @(posedge clk);
      {rst_drop, rst_wdog, rst_user, rst_soft} <= 4'h0;
      xfer(0, `REG_RST_CAUSE, n + 1, 2'h0);
    end
    for (n = 0; n < 8; n++) begin
      a = $urandom;
      if (n[0]) a[31:12] = 20'hfffff;
      sys_addr <= a;
      @(negedge clk);
      chk(sys_sel, a[31:12] == 20'hfffff);
    end
    results();
  end
  initial begin
    #800000;
    chk(0, 1);
    results();
  end
endmodule // nvm_bits_tb_top
`default_nettype wire
